// >>> hw/cafp_blank_timer.sv
// Programmable blanking timer counted in fixed time steps.
`include "cafp_consts.svh"

module cafp_blank_timer #(
   parameter int W    = `CAFP_BLANK_W,
   parameter int STEP = `CAFP_BLANK_STEP_CYC
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         start,
   input  wire logic [W-1:0] len,
   output logic              active
);
   typedef struct packed {
      logic [15:0]  pre;
      logic [W-1:0] cnt;
   } cafp_timer_state_type;

   cafp_timer_state_type st_reg;
   cafp_timer_state_type st_next;

   // Step divider restarts with every start so the length is exact.
   always_comb begin
      st_next = st_reg;
      if (start) begin
         st_next.pre = 16'h0000;
         st_next.cnt = len;
      end else if (st_reg.cnt != '0) begin
         if (st_reg.pre == 16'(STEP - 1)) begin
            st_next.pre = 16'h0000;
            st_next.cnt = st_reg.cnt - W'(1);
         end else begin
            st_next.pre = st_reg.pre + 16'h0001;
         end
      end
   end

   // State register.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Blanking lasts len steps from the cycle after start.
   assign active = (st_reg.cnt != '0);
endmodule

// >>> hw/cafp_consts.svh
// Constants for the category A fault protection block.
`ifndef CAFP_CONSTS_SVH
`define CAFP_CONSTS_SVH

// =====================================================================
// Clock and blanking time base
`define CAFP_CLK_PERIOD_NS   8
`define CAFP_BLANK_STEP_NS   100
`define CAFP_BLANK_STEP_CYC  ((`CAFP_BLANK_STEP_NS + `CAFP_CLK_PERIOD_NS - 1) / `CAFP_CLK_PERIOD_NS)

// =====================================================================
// Field widths and positions
`define CAFP_BLANK_W         8
`define CAFP_THR_W           2
`define CAFP_SYNC_W          4
`define CAFP_SYNC_SAT        0
`define CAFP_SYNC_OC1        1
`define CAFP_SYNC_OC2        2
`define CAFP_SYNC_EN         3

// =====================================================================
// Timer channels
`define CAFP_TMR_N           3
`define CAFP_TMR_SAT_ON      0
`define CAFP_TMR_OC_ON       1
`define CAFP_TMR_SAT_OFF     2

`endif

// >>> hw/cafp_fault_protection.sv
// Category A fault protection: saturation, overcurrent and external enable.
// Functional notes
// - Class A event turns output stage off; stays disabled until reactivation.
// - Class B event disables device and stage; only full reinit recovers.
// - Class C events only raise a notification, output stage untouched.
// - At turn-on, hold saturation pin low for blanking time, then compare.
// - Saturation above threshold: safe turn-off, error flag, fault A notify.
// - Saturation comparator result is visible in a status bit.
// - Saturation detection is inactive while PWM is off.
// - Saturation threshold comes from a software configuration field.
// - At turn-off pull pin down for plateau, then blanking after hard turn-off.
// - With clamp enabled, clamp saturation pin to ground during PWM off.
// - At turn-on, ignore overcurrent input for overcurrent blanking time.
// - Two overcurrent status bits, both masked during blanking.
// - Overcurrent above first threshold: safe turn-off, flag, fault A notify.
// - Overcurrent above second threshold sets a sticky status bit.
// - Overcurrent detection is inactive while PWM is off.
// - Saturation and overcurrent protection run together, each reacting alone.
// - Enable valid-to-invalid: regular turn-off, enable flag, fault A notify.
// - Present enable validity is visible in a status bit.
// - Both overcurrent threshold crossings are visible independently.
`include "cafp_consts.svh"

module cafp_fault_protection (
   input  wire logic                  core_clk,
   input  wire logic                  rst_n,
   input  wire logic                  pwm_on_cmd,
   input  wire logic                  two_level_turnoff,
   input  wire logic                  hard_turnoff_start,
   input  wire logic                  vce_sense_pin,
   input  wire logic                  overcurrent_sense_pin,
   input  wire logic                  overcurrent_level2_pin,
   input  wire logic                  external_enable_pin,
   input  wire logic                  reactivate,
   input  wire logic                  reinit,
   input  wire logic                  class_b_event,
   input  wire logic                  class_c_event,
   input  wire cafp_pkg::cafp_cfg_type   cfg,
   input  wire cafp_pkg::cafp_clear_type flag_clear,
   output cafp_pkg::cafp_flags_type      flags,
   output cafp_pkg::cafp_status_type     status,
   output cafp_pkg::cafp_ctrl_type       ctrl
);
   import cafp_pkg::*;

   // ==================================================================
   // Declarations
   cafp_core_state_type      st_reg;
   cafp_core_state_type      st_next;
   logic [`CAFP_TMR_N-1:0]   tmr_start;
   logic [`CAFP_TMR_N-1:0]   tmr_active;
   logic [`CAFP_BLANK_W-1:0] tmr_len [`CAFP_TMR_N];
   logic                     running;
   logic                     on_start;
   logic                     sat_eval;
   logic                     oc_eval;
   logic                     sat_hit;
   logic                     oc1_hit;
   logic                     oc2_hit;
   logic                     en_fall;
   logic                     class_a;

   // ==================================================================
   // Event decode

   // The stage is running only in the run state.
   assign running  = (st_reg.operating_state == CAFP_ST_RUN);

   // A turn-on sequence begins on the rising PWM command.
   assign on_start = pwm_on_cmd && !st_reg.pwm_prev && running;

   // Saturation is judged only with PWM on and the pin released.
   assign sat_eval = running && pwm_on_cmd && st_reg.pwm_prev
                     && !tmr_active[`CAFP_TMR_SAT_ON]
                     && !st_reg.ctrl.vce_sense_oe;

   // Overcurrent is judged only with PWM on and blanking over.
   assign oc_eval  = running && pwm_on_cmd && st_reg.pwm_prev
                     && !tmr_active[`CAFP_TMR_OC_ON];

   // Each comparator reacts on its own, so both can fire together.
   assign sat_hit  = sat_eval && st_reg.sync2[`CAFP_SYNC_SAT];
   assign oc1_hit  = oc_eval && st_reg.sync2[`CAFP_SYNC_OC1];
   assign oc2_hit  = oc_eval && st_reg.sync2[`CAFP_SYNC_OC2];

   // A valid enable that turns invalid is a fault.
   assign en_fall  = st_reg.en_prev && !st_reg.sync2[`CAFP_SYNC_EN];

   // Any of these is an event of class A.
   assign class_a  = sat_hit || oc1_hit || en_fall;

   // ==================================================================
   // Blanking timers

   // Channel starts: two at turn-on, one at the hard turn-off edge.
   assign tmr_start[`CAFP_TMR_SAT_ON]  = on_start;
   assign tmr_start[`CAFP_TMR_OC_ON]   = on_start;
   assign tmr_start[`CAFP_TMR_SAT_OFF] = hard_turnoff_start;

   // Channel lengths from the configuration.
   assign tmr_len[`CAFP_TMR_SAT_ON]  = cfg.sat_blanking_time;
   assign tmr_len[`CAFP_TMR_OC_ON]   = cfg.overcurrent_blanking_time;
   assign tmr_len[`CAFP_TMR_SAT_OFF] = cfg.sat_blanking_time;

   // One timer per channel.
   genvar gi;
   generate
      for (gi = 0; gi < `CAFP_TMR_N; gi++) begin : g_tmr
         cafp_blank_timer #(
            .W    (`CAFP_BLANK_W),
            .STEP (`CAFP_BLANK_STEP_CYC)
         ) u_tmr (
            .core_clk (core_clk),
            .rst_n    (rst_n),
            .start    (tmr_start[gi]),
            .len      (tmr_len[gi]),
            .active   (tmr_active[gi])
         );
      end
   endgenerate

   // ==================================================================
   // Next state
   always_comb begin
      st_next = st_reg;

      // Pins pass two flops before anything reads them.
      st_next.sync1 = {external_enable_pin, overcurrent_level2_pin,
                       overcurrent_sense_pin, vce_sense_pin};
      st_next.sync2 = st_reg.sync1;
      st_next.pwm_prev = pwm_on_cmd;
      st_next.en_prev  = st_reg.sync2[`CAFP_SYNC_EN];

      // Sticky flags: a set in the clearing cycle wins.
      st_next.flags.sat_error_flag =
         (st_reg.flags.sat_error_flag && !flag_clear.sat_error) || sat_hit;
      st_next.flags.overcurrent_error_flag =
         (st_reg.flags.overcurrent_error_flag && !flag_clear.overcurrent_error)
         || oc1_hit;
      st_next.flags.enable_error_flag =
         (st_reg.flags.enable_error_flag && !flag_clear.enable_error) || en_fall;
      st_next.flags.overcurrent_level2_sticky =
         (st_reg.flags.overcurrent_level2_sticky && !flag_clear.overcurrent_level2)
         || oc2_hit;
      st_next.flags.notify_c_flag =
         (st_reg.flags.notify_c_flag && !flag_clear.notify_c) || class_c_event;

      // Operating state; class B outranks class A.
      case (st_reg.operating_state)
         CAFP_ST_RUN: begin
            if (class_b_event) begin
               st_next.operating_state = CAFP_ST_DIS_B;
            end else if (class_a) begin
               st_next.operating_state = CAFP_ST_DIS_A;
            end
         end
         CAFP_ST_DIS_A: begin
            if (class_b_event) begin
               st_next.operating_state = CAFP_ST_DIS_B;
            end else if (reactivate && !class_a) begin
               st_next.operating_state = CAFP_ST_RUN;
            end
         end
         CAFP_ST_DIS_B: begin
            if (reinit && !class_b_event) begin
               st_next.operating_state = CAFP_ST_RUN;
            end
         end
         default: begin
            st_next.operating_state = CAFP_ST_DIS_B;
         end
      endcase

      // Live status; overcurrent bits are blanked with the evaluation.
      st_next.status.sat_compare_status = st_reg.sync2[`CAFP_SYNC_SAT];
      st_next.status.overcurrent_compare1_status =
         st_reg.sync2[`CAFP_SYNC_OC1] && !tmr_active[`CAFP_TMR_OC_ON];
      st_next.status.overcurrent_compare2_status =
         st_reg.sync2[`CAFP_SYNC_OC2] && !tmr_active[`CAFP_TMR_OC_ON];
      st_next.status.enable_valid_status = st_reg.sync2[`CAFP_SYNC_EN];
      st_next.status.disabled_a = (st_next.operating_state == CAFP_ST_DIS_A);
      st_next.status.disabled_b = (st_next.operating_state == CAFP_ST_DIS_B);

      // Turn-off requests are single-cycle pulses.
      st_next.ctrl.safe_turnoff_req    = sat_hit || oc1_hit;
      st_next.ctrl.regular_turnoff_req = en_fall;
      st_next.ctrl.output_stage_off =
         (st_next.operating_state != CAFP_ST_RUN);

      // Fault A pin is low while any class A flag stands.
      st_next.ctrl.fault_a_notify_n =
         !(st_next.flags.sat_error_flag || st_next.flags.overcurrent_error_flag
           || st_next.flags.enable_error_flag);

      // Saturation pin pull-down: turn-on blanking, plateau, tail, clamp.
      st_next.ctrl.vce_sense_out = 1'b0;
      st_next.ctrl.vce_sense_oe =
         on_start || tmr_active[`CAFP_TMR_SAT_ON]
         || two_level_turnoff || hard_turnoff_start
         || tmr_active[`CAFP_TMR_SAT_OFF]
         || (cfg.sat_clamp_enable && !pwm_on_cmd);

      // Threshold selection passes to the comparator.
      st_next.ctrl.sat_threshold_out = cfg.sat_threshold_select;
   end

   // ==================================================================
   // State register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg                       <= '0;
         st_reg.operating_state       <= CAFP_ST_RUN;
         st_reg.ctrl.fault_a_notify_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register.
   assign flags  = st_reg.flags;
   assign status = st_reg.status;
   assign ctrl   = st_reg.ctrl;

   // ==================================================================
   // Assertions

   // Saturation fault gives turn-off, flag and notification.
   a_sat_reaction: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      sat_hit |=> ctrl.safe_turnoff_req && flags.sat_error_flag
                  && !ctrl.fault_a_notify_n)
      else $error("saturation fault reaction missing");

   // Overcurrent fault gives turn-off, flag and notification.
   a_oc_reaction: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      oc1_hit |=> ctrl.safe_turnoff_req && flags.overcurrent_error_flag
                  && !ctrl.fault_a_notify_n)
      else $error("overcurrent fault reaction missing");

   // Enable loss gives regular turn-off, flag and notification.
   a_en_reaction: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      en_fall |=> ctrl.regular_turnoff_req && flags.enable_error_flag
                  && !ctrl.fault_a_notify_n)
      else $error("enable fault reaction missing");

   // No safe turn-off is raised while PWM is off.
   a_pwm_off_quiet: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !pwm_on_cmd |=> !ctrl.safe_turnoff_req)
      else $error("protection acted with PWM off");

   // Class A disable holds without a reactivation.
   a_dis_a_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      status.disabled_a && !reactivate && !class_b_event
      |=> status.disabled_a && ctrl.output_stage_off)
      else $error("class A disable released early");

   // Class B disable holds until reinitialisation.
   a_dis_b_hold: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      st_reg.operating_state == CAFP_ST_DIS_B && !reinit
      |=> st_reg.operating_state == CAFP_ST_DIS_B)
      else $error("class B disable released without reinit");

   // Class C event alone leaves the stage running.
   a_class_c_only: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      class_c_event && running && !class_a && !class_b_event
      |=> !ctrl.output_stage_off && flags.notify_c_flag)
      else $error("class C event changed the stage");

   // Turn-on holds the saturation pin low.
   a_sat_blank_low: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      on_start && cfg.sat_blanking_time != '0
      |=> ctrl.vce_sense_oe [*2])
      else $error("saturation pin not held at turn-on");

   // Clamp pulls the pin whenever PWM is off.
   a_clamp_pin: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      cfg.sat_clamp_enable && !pwm_on_cmd
      |=> ctrl.vce_sense_oe && !ctrl.vce_sense_out)
      else $error("saturation clamp not applied");

   // Overcurrent status is masked while blanking.
   a_oc_status_mask: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      tmr_active[`CAFP_TMR_OC_ON] |=> !status.overcurrent_compare1_status
                                      && !status.overcurrent_compare2_status)
      else $error("overcurrent status not blanked");

   // A set flag survives a cycle without its clear.
   a_flag_sticky: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      flags.sat_error_flag && !flag_clear.sat_error
      |=> flags.sat_error_flag)
      else $error("saturation flag lost without clear");

   // Plateau holds the pin low.
   a_plateau_low: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      two_level_turnoff |=> ctrl.vce_sense_oe)
      else $error("plateau pin not low");

   // Hard turn-off holds it with no gap.
   a_hard_tail: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      hard_turnoff_start |=> ctrl.vce_sense_oe)
      else $error("hard turn-off pin not low");

   // Level two sets its sticky bit.
   a_lvl2_sticky: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      oc2_hit |=> flags.overcurrent_level2_sticky)
      else $error("sticky bit not set");

   // No sticky set with PWM off.
   a_lvl2_pwm_off: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      !pwm_on_cmd && !flags.overcurrent_level2_sticky
      |=> !flags.overcurrent_level2_sticky)
      else $error("sticky set with PWM off");

   // Enable loss reads as invalid.
   a_en_status: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      ctrl.regular_turnoff_req |-> !status.enable_valid_status)
      else $error("enable status still valid");

   // Selection reaches the comparator.
   a_thr_follow: assert property (
      @(posedge core_clk) disable iff (!rst_n)
      1'b1 |=> ctrl.sat_threshold_out == $past(cfg.sat_threshold_select))
      else $error("threshold not applied");

endmodule

// >>> hw/cafp_pkg.sv
// Types shared by the category A fault protection block.
`include "cafp_consts.svh"

package cafp_pkg;

   // ==================================================================
   // Operating state, one-hot.
   typedef enum logic [2:0] {
      CAFP_ST_RUN   = 3'h1,
      CAFP_ST_DIS_A = 3'h2,
      CAFP_ST_DIS_B = 3'h4
   } cafp_state_type;

   // ==================================================================
   // Configuration written by software.
   typedef struct packed {
      logic [`CAFP_BLANK_W-1:0] sat_blanking_time;
      logic [`CAFP_BLANK_W-1:0] overcurrent_blanking_time;
      logic [`CAFP_THR_W-1:0]   sat_threshold_select;
      logic                     sat_clamp_enable;
   } cafp_cfg_type;

   // One-cycle clear strobes from software.
   typedef struct packed {
      logic sat_error;
      logic overcurrent_error;
      logic enable_error;
      logic overcurrent_level2;
      logic notify_c;
   } cafp_clear_type;

   // Sticky flags.
   typedef struct packed {
      logic sat_error_flag;
      logic overcurrent_error_flag;
      logic enable_error_flag;
      logic overcurrent_level2_sticky;
      logic notify_c_flag;
   } cafp_flags_type;

   // Live status bits.
   typedef struct packed {
      logic sat_compare_status;
      logic overcurrent_compare1_status;
      logic overcurrent_compare2_status;
      logic enable_valid_status;
      logic disabled_a;
      logic disabled_b;
   } cafp_status_type;

   // Controls towards the output stage and pins.
   typedef struct packed {
      logic                   safe_turnoff_req;
      logic                   regular_turnoff_req;
      logic                   output_stage_off;
      logic                   fault_a_notify_n;
      logic                   vce_sense_out;
      logic                   vce_sense_oe;
      logic [`CAFP_THR_W-1:0] sat_threshold_out;
   } cafp_ctrl_type;

   // Whole state of the main module.
   typedef struct packed {
      logic [`CAFP_SYNC_W-1:0] sync1;
      logic [`CAFP_SYNC_W-1:0] sync2;
      logic                    pwm_prev;
      logic                    en_prev;
      cafp_state_type          operating_state;
      cafp_flags_type          flags;
      cafp_status_type         status;
      cafp_ctrl_type           ctrl;
   } cafp_core_state_type;

endpackage

// >>> tb/cafp_stage_model.sv
// Behavioural model of the power stage comparators and the host enable line.
module cafp_stage_model #(
   parameter int lag_ns = 3
) (
   input  wire logic       sat_short,
   input  wire logic [1:0] oc_level,
   input  wire logic       enable_ok,
   input  wire logic       vce_sense_oe,
   output wire logic       vce_sense_pin,
   output wire logic       overcurrent_sense_pin,
   output wire logic       overcurrent_level2_pin,
   output wire logic       external_enable_pin
);
   timeunit 1ns;
   timeprecision 100ps;

   // The sense pin reads low while the driver pulls it down, even with a shorted stage.
   assign #(lag_ns) vce_sense_pin = sat_short & ~vce_sense_oe;
   // A crossing of the second threshold always comes with the first one.
   assign #(lag_ns) overcurrent_sense_pin  = (oc_level != 2'h0);
   assign #(lag_ns) overcurrent_level2_pin = (oc_level == 2'h2);
   // The enable line reaches the pins late, as an asynchronous source does.
   assign #(lag_ns) external_enable_pin = enable_ok;
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the category A fault protection block.
`include "cafp_consts.svh"

`define CAFP_CMP(nm, e, g) \
   checks_done++; \
   if ((g) !== (e)) begin \
      failures++; \
      $display("mismatch %s expected %h seen %h", nm, e, g); \
   end

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import cafp_pkg::*;

   // =====================================================================
   // Signals and bookkeeping
   typedef struct {string nm; int lo; logic [1:0] m; logic [1:0] e;} cafp_note_type;
   localparam int sat_err = 18, oc_err = 17, en_err = 16, lvl2 = 15, note_c = 14;
   localparam int sat_cmp = 13, oc1 = 12, oc2 = 11, en_ok = 10, dis_a = 9, dis_b = 8;
   localparam int safe = 7, regular = 6, stage_off = 5, notify_n = 4, oe = 2, thr = 0;
   localparam int step = `CAFP_BLANK_STEP_CYC;
   logic           core_clk, rst_n, pwm_on_cmd, two_level_turnoff, hard_turnoff_start;
   logic           reactivate, reinit, class_b_event, class_c_event, sat_short, enable_ok;
   logic [1:0]     oc_level;
   logic           vce_sense_pin, overcurrent_sense_pin, overcurrent_level2_pin;
   logic           external_enable_pin;
   cafp_cfg_type    cfg;
   cafp_clear_type  flag_clear;
   cafp_flags_type  flags;
   cafp_status_type status;
   cafp_ctrl_type   ctrl;
   logic [18:0]    obs;
   cafp_note_type  q[$];
   event           look;
   int             failures = 0, checks_done = 0, seed = 32'hdc8b, sblank, oblank;

   assign obs = {flags, status, ctrl};

   // =====================================================================
   // Design, stage model and clock
   cafp_fault_protection cafp_fault_protection_i (.core_clk, .rst_n, .pwm_on_cmd,
      .two_level_turnoff, .hard_turnoff_start, .vce_sense_pin, .overcurrent_sense_pin,
      .overcurrent_level2_pin, .external_enable_pin, .reactivate, .reinit, .class_b_event,
      .class_c_event, .cfg, .flag_clear, .flags, .status, .ctrl);
   cafp_stage_model #(.lag_ns(5)) cafp_stage_model_i (.sat_short, .oc_level, .enable_ok,
      .vce_sense_oe(ctrl.vce_sense_oe), .vce_sense_pin, .overcurrent_sense_pin,
      .overcurrent_level2_pin, .external_enable_pin);

   // The clock toggles every half period of 4 ns.
   initial begin
      core_clk = 1'h0;
      forever #4 core_clk = ~core_clk;
   end

   // =====================================================================
   // Tasks
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   task automatic note(input string nm, input int lo, input logic [1:0] e,
                       input logic [1:0] m = 2'h1);
      q.push_back('{nm, lo, m, e});
      -> look;
   endtask

   task automatic finish_test();
      #1;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Waits a bounded number of cycles for one output bit to reach a level.
   task automatic await(input int lo, input logic v, input int bound);
      int n;
      n = 0;
      while (obs[lo] !== v && n < bound) begin
         cyc(1);
         n++;
      end
      if (n >= bound) begin
         failures++;
         $display("mismatch wait bit %0d expected %h seen %h", lo, v, obs[lo]);
         finish_test();
      end
   endtask

   // Clears every flag and leaves the class A disable.
   task automatic recover();
      flag_clear = '1;
      reactivate = 1'h1;
      cyc(1);
      flag_clear = '0;
      reactivate = 1'h0;
      cyc(2);
      note("notify_n", notify_n, 2'h1);
      note("dis_a", dis_a, 2'h0);
   endtask

   // =====================================================================
   // Monitor: compares each noted expectation with the outputs when it is due.
   initial begin
      cafp_note_type n;
      logic [1:0] got;
      forever begin
         @(look);
         while (q.size() > 0) begin
            n = q.pop_front();
            got = 2'(obs >> n.lo) & n.m;
            `CAFP_CMP(n.nm, n.e, got)
         end
      end
   end

   // =====================================================================
   // Main sequence, driven at the falling edge.
   initial begin
      {rst_n, pwm_on_cmd, two_level_turnoff, hard_turnoff_start, reactivate} = '0;
      {reinit, class_b_event, class_c_event, sat_short, oc_level} = '0;
      enable_ok = 1'h1;
      flag_clear = '0;
      sblank = 1 + ($random(seed) & 1);
      oblank = 1 + ($random(seed) & 1);
      cfg = '{8'(sblank), 8'(oblank), 2'h0, 1'h0};
      cyc(5);
      rst_n = 1'h1;
      cyc(8);
      note("notify_n", notify_n, 2'h1);
      note("en_valid", en_ok, 2'h1);
      $display("test reset done");
      // Shorted stage and sense-path injection while idle: nothing may trip.
      sat_short = 1'h1;
      oc_level = 2'h2;
      cyc(30);
      note("sat_err", sat_err, 2'h0);
      note("oc_err", oc_err, 2'h0);
      note("sat_cmp", sat_cmp, 2'h1);
      oc_level = 2'h0;
      $display("test idle done");
      // Saturation fault once the turn-on blanking has run out.
      pwm_on_cmd = 1'h1;
      cyc(2);
      note("oe_blank", oe, 2'h1);
      cyc(step * sblank - 2);
      note("sat_err", sat_err, 2'h0);
      await(sat_err, 1'h1, 10);
      note("safe", safe, 2'h1);
      note("notify_n", notify_n, 2'h0);
      note("dis_a", dis_a, 2'h1);
      note("stage_off", stage_off, 2'h1);
      pwm_on_cmd = 1'h0;
      sat_short = 1'h0;
      cyc(6);
      note("sat_err", sat_err, 2'h1);
      note("dis_a", dis_a, 2'h1);
      recover();
      $display("test saturation done");
      // Overcurrent fault after its own blanking, both crossings present.
      oc_level = 2'h2;
      pwm_on_cmd = 1'h1;
      cyc(3);
      note("oc1", oc1, 2'h0);
      note("oc2", oc2, 2'h0);
      cyc(step * oblank - 3);
      note("oc_err", oc_err, 2'h0);
      await(oc_err, 1'h1, 10);
      note("safe", safe, 2'h1);
      note("notify_n", notify_n, 2'h0);
      note("lvl2", lvl2, 2'h1);
      note("oc1", oc1, 2'h1);
      note("oc2", oc2, 2'h1);
      note("sat_err", sat_err, 2'h0);
      pwm_on_cmd = 1'h0;
      oc_level = 2'h0;
      flag_clear.overcurrent_error = 1'h1;
      cyc(1);
      flag_clear = '0;
      cyc(2);
      note("oc_err", oc_err, 2'h0);
      note("lvl2", lvl2, 2'h1);
      note("notify_n", notify_n, 2'h1);
      recover();
      $display("test overcurrent done");
      // External enable turning invalid.
      enable_ok = 1'h0;
      await(en_err, 1'h1, 10);
      note("regular", regular, 2'h1);
      note("notify_n", notify_n, 2'h0);
      note("en_valid", en_ok, 2'h0);
      enable_ok = 1'h1;
      cyc(6);
      recover();
      note("en_err", en_err, 2'h0);
      $display("test enable done");
      // Clamp during PWM off, then the turn-off pull-down sequence.
      cfg.sat_clamp_enable = 1'h1;
      cyc(3);
      note("oe_clamp", oe, 2'h1);
      note("sense_out", 3, 2'h0);
      cfg.sat_clamp_enable = 1'h0;
      cyc(3);
      note("oe_clamp", oe, 2'h0);
      pwm_on_cmd = 1'h1;
      cyc(step * sblank + 6);
      pwm_on_cmd = 1'h0;
      two_level_turnoff = 1'h1;
      cyc(3);
      note("oe_plateau", oe, 2'h1);
      two_level_turnoff = 1'h0;
      hard_turnoff_start = 1'h1;
      cyc(1);
      hard_turnoff_start = 1'h0;
      note("oe_hard", oe, 2'h1);
      cyc(step * sblank - 4);
      note("oe_hard", oe, 2'h1);
      cyc(8);
      note("oe_hard", oe, 2'h0);
      $display("test turn-off done");
      // Class C only notifies; class B needs a full reinitialisation.
      class_c_event = 1'h1;
      cyc(1);
      class_c_event = 1'h0;
      cyc(2);
      note("note_c", note_c, 2'h1);
      note("stage_off", stage_off, 2'h0);
      note("notify_n", notify_n, 2'h1);
      class_b_event = 1'h1;
      cyc(1);
      class_b_event = 1'h0;
      cyc(2);
      note("dis_b", dis_b, 2'h1);
      note("stage_off", stage_off, 2'h1);
      recover();
      note("dis_b", dis_b, 2'h1);
      reinit = 1'h1;
      cyc(1);
      reinit = 1'h0;
      cyc(2);
      note("dis_b", dis_b, 2'h0);
      $display("test classes done");
      // Random threshold codes, each passed to the comparator.
      for (int i = 0; i < 4; i++) begin
         cfg.sat_threshold_select = 2'(i) ^ 2'($random(seed));
         cyc(3);
         note("thr", thr, cfg.sat_threshold_select, 2'h3);
      end
      $display("test threshold done");
      finish_test();
   end
endmodule
